// >>> bench/ext_mem_model.sv
// Behavioural external memory that answers each word after a set latency.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic        clock,
  input  wire logic        ext_req_q,
  input  wire logic        ext_write_q,
  input  wire logic [31:0] ext_addr_q,
  input  wire logic [31:0] ext_wdata_q,
  input  wire logic        err_en,
  input  wire logic [7:0]  lat,
  output var  logic        ext_done,
  output var  logic        ext_error,
  output var  logic [31:0] ext_rdata,
  output var  logic [31:0] wr_cnt,
  output var  logic [31:0] rd_cnt,
  output var  logic [31:0] wr_last
);
  logic [7:0] wait_q;
  // Counters start clean and survive a design reset, so lost queued writes stay visible.
  initial begin
    {ext_done, ext_error, wait_q} = '0;
    {ext_rdata, wr_cnt, rd_cnt, wr_last} = '0;
  end
  // One word per request; read data toggles between answers so a stale value never passes.
  always @(posedge clock) begin
    ext_done  <= 1'b0;
    ext_error <= 1'b0;
    ext_rdata <= ~ext_rdata;
    wait_q    <= (ext_req_q && !ext_done) ? wait_q + 8'h01 : 8'h00;
    if (ext_req_q && !ext_done && wait_q + 8'h01 >= lat) begin
      wait_q    <= 8'h00;
      ext_done  <= 1'b1;
      ext_error <= err_en;
      wr_cnt    <= wr_cnt + {31'h0, ext_write_q};
      rd_cnt    <= rd_cnt + {31'h0, !ext_write_q};
      if (ext_write_q) begin
        wr_last <= ext_wdata_q;  // Keeps the last word written so write data is visible.
      end
      if (!ext_write_q) begin
        ext_rdata <= ext_addr_q ^ 32'h5a5a_0000;  // Word data is its address folded.
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the cache, write buffer and area attribute block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] ID  = 32'h0bad_cafe;  // Arbitrary identity value.
  localparam logic [31:0] KEY = 32'h5a5a_0000;  // Same fold as the memory model uses.
  typedef struct packed {logic [3:0] r; logic [31:0] w; logic [31:0] e;} row_t;
  logic        clock, rst_b, cp_wr, cp_rd, core_req, core_write, core_instr, core_seq;
  logic        core_atomic, core_priv, core_done_q, core_abort_q, ext_req_q, ext_write_q;
  logic        ext_done, ext_error, err_en, ab, e1;
  logic [2:0]  core_area;
  logic [3:0]  cp_reg;
  logic [7:0]  lat;
  logic [31:0] cp_wdata, cp_rdata_q, core_addr, core_wdata, core_rdata_q, ext_addr_q;
  logic [31:0] ext_wdata_q, ext_rdata, wr_cnt, rd_cnt, wr_last, rd, n0;
  int          cyc, error_cnt = 0, n_compared = 0;
  row_t rows [9] = '{'{4'h2, 32'hffff_ffff, 32'h0000_00ff}, '{4'h3, 32'hffff_ffff, 32'h0000_00ff},
    '{4'h5, 32'hffff_ffff, 32'h0000_ffff}, '{4'h4, 32'hffff_ffff, 32'h0000_0000},
    '{4'h0, 32'hffff_ffff, ID}, '{4'h7, 32'hffff_ffff, 32'h0000_0000},
    '{4'h8, 32'hffff_ffff, 32'h0000_0000}, '{4'hf, 32'hffff_ffff, 32'h0000_0000},
    '{4'h1, 32'h0000_0001, 32'h0000_0001}};

  cache_wbuf_region_attr_ctrl #(.ID_VALUE(ID)) dut (
    .clock, .rst_b, .cp_wr, .cp_rd, .cp_reg, .cp_wdata, .cp_rdata_q, .core_req, .core_write,
    .core_instr, .core_seq, .core_atomic, .core_priv, .core_area, .core_addr, .core_wdata,
    .core_done_q, .core_abort_q, .core_rdata_q, .ext_req_q, .ext_write_q, .ext_addr_q,
    .ext_wdata_q, .ext_done, .ext_error, .ext_rdata);
  ext_mem_model mem (.clock, .ext_req_q, .ext_write_q, .ext_addr_q, .ext_wdata_q, .err_en, .lat,
    .ext_done, .ext_error, .ext_rdata, .wr_cnt, .rd_cnt, .wr_last);

  // A 50 ns clock.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Every drive lands one nanosecond after a rising edge.
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cpw(input logic [3:0] r, input logic [31:0] d);
    cp_reg   = r;
    cp_wdata = d;
    cp_wr    = 1'b1;
    tick();
    cp_wr = 1'b0;
    tick();
  endtask
  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic cpr(input logic [3:0] r);
    cp_reg = r;
    cp_rd  = 1'b1;
    tick();
    cp_rd = 1'b0;
    rd    = cp_rdata_q;
    tick();
  endtask
  // The request is held until done is seen, then released a clock later.
  task automatic acc(input logic w, sq, at, pv, input logic [2:0] ar, input logic [31:0] a, d);
    core_write  = w;
    core_seq    = sq;
    core_atomic = at;
    core_priv   = pv;
    core_area   = ar;
    core_addr   = a;
    core_wdata  = d;
    core_req    = 1'b1;
    cyc         = 0;
    do begin
      tick();
      cyc++;
    end while (core_done_q !== 1'b1 && cyc < 3000);
    // A request that is never answered counts against the run.
    if (cyc >= 3000) error_cnt++;
    ab = core_abort_q;
    rd = core_rdata_q;
    tick();
    core_req = 1'b0;
    tick();
  endtask
  task automatic test_done;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: register table rows first, then the hand-written cases.
  initial begin
    {cp_wr, cp_rd, core_req, core_write, core_instr, core_seq, core_atomic} = '0;
    {core_priv, err_en, rst_b, core_area, cp_reg} = '0;
    {cp_wdata, core_addr, core_wdata} = '0;
    lat = 8'h02;
    repeat (8) @(posedge clock);
    #1 rst_b = 1'b1;
    foreach (rows[i]) begin
      cpr(rows[i].r);
      chk("reset_value", (rows[i].r == 4'h0) ? ID : 32'h0, rd);
    end
    foreach (rows[i]) begin
      cpw(rows[i].r, rows[i].w);
      cpr(rows[i].r);
      chk("reg_read", rows[i].e, rd);
    end
    // Protection off: no abort and nothing cached even with every area cacheable.
    cpw(4'h1, 32'h0);
    cpw(4'h2, 32'h0000_00ff);
    cpw(4'h5, 32'h0);
    n0 = rd_cnt;
    acc(1'b0, 1'b0, 1'b0, 1'b0, 3'd0, 32'h0000_0200, 32'h0);
    chk("off_abort", 32'h0, {31'h0, ab});
    acc(1'b0, 1'b0, 1'b0, 1'b0, 3'd0, 32'h0000_0200, 32'h0);
    chk("off_data", KEY ^ 32'h0000_0200, rd);
    chk("off_reads", n0 + 32'h2, rd_cnt);
    // Linefill, hit with cache disabled, write-through, uncacheable reads and flush.
    cpw(4'h5, 32'h0000_ffff);
    cpw(4'h2, 32'h0000_0001);
    cpw(4'h1, 32'h0000_0005);
    n0 = rd_cnt;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0104, 32'h0);
    chk("fill_data", KEY ^ 32'h0000_0104, rd);
    chk("fill_words", n0 + 32'h4, rd_cnt);
    cpw(4'h1, 32'h0000_0001);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_010c, 32'h0);
    chk("hit_off_data", KEY ^ 32'h0000_010c, rd);
    n0 = wr_cnt;
    acc(1'b1, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0104, 32'hdead_0001);
    chk("wthru_cnt", n0 + 32'h1, wr_cnt);
    chk("wthru_data", 32'hdead_0001, wr_last);
    n0 = rd_cnt;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0104, 32'h0);
    chk("whit_data", 32'hdead_0001, rd);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd1, 32'h0000_0300, 32'h0);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd1, 32'h0000_0300, 32'h0);
    chk("unc_reads", n0 + 32'h2, rd_cnt);
    cpw(4'h1, 32'h0000_0005);
    cpw(4'h7, 32'h0);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0104, 32'h0);
    chk("flush_data", KEY ^ 32'h0000_0104, rd);
    chk("flush_fill", n0 + 32'h6, rd_cnt);
    // Every permission code against both privilege levels and both directions.
    for (int p = 0; p < 4; p++) begin
      cpw(4'h5, 32'h0000_ffcf | (32'(p) << 4));
      for (int k = 0; k < 4; k++) begin
        e1 = (p == 0) || (!k[1] && (p == 1 || (p == 2 && k[0])));
        acc(k[0], 1'b0, 1'b0, k[1], 3'd2, 32'h0000_0400, 32'h0);
        chk("perm_abort", {31'h0, e1}, {31'h0, ab});
      end
    end
    // Split 11: data owns bank 3 alone, so two data lines of one index evict each other.
    cpw(4'h1, 32'h0000_00d5);
    cpw(4'h7, 32'h0);
    n0 = rd_cnt;
    core_instr = 1'b1;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_1100, 32'h0);
    core_instr = 1'b0;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0100, 32'h0);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0900, 32'h0);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0100, 32'h0);
    chk("split_fills", n0 + 32'h10, rd_cnt);
    // Snapshot: split off with the field kept locks the instruction banks over a flush.
    cpw(4'h1, 32'h0000_00c5);
    cpw(4'h7, 32'h0);
    core_instr = 1'b1;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_1100, 32'h0);
    core_instr = 1'b0;
    chk("snap_data", KEY ^ 32'h0000_1100, rd);
    chk("snap_reads", n0 + 32'h10, rd_cnt);
    cpw(4'h1, 32'h0000_0055);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h0000_0900, 32'h0);
    chk("split_one_data", KEY ^ 32'h0000_0900, rd);
    // Slow memory: four addresses fit, the fifth stalls, an atomic write waits for all.
    lat = 8'h28;
    cpw(4'h3, 32'h0000_0008);
    cpw(4'h1, 32'h0000_0009);
    n0 = wr_cnt;
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 1'b0, 1'b0, 1'b1, 3'd3, 32'h0000_1000 + 32'(16 * i), 32'(i));
      chk("addr_slots", {31'h0, i < 4}, {31'h0, cyc <= 2});
    end
    acc(1'b1, 1'b0, 1'b1, 1'b1, 3'd3, 32'h0000_1100, 32'h0);
    chk("atomic_wait", n0 + 32'h6, wr_cnt);
    // One burst fills all eight data slots; a ninth word stalls.
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, i != 0, 1'b0, 1'b1, 3'd3, 32'h0000_2000 + 32'(4 * i), 32'(i));
      chk("data_slots", {31'h0, i < 8}, {31'h0, cyc <= 2});
    end
    // Errors and disable while queued: the queue still drains, the unbuffered write aborts.
    err_en = 1'b1;
    cpw(4'h1, 32'h0000_0001);
    acc(1'b1, 1'b0, 1'b0, 1'b1, 3'd4, 32'h0000_3000, 32'h0);
    chk("drain_cnt", n0 + 32'h10, wr_cnt);
    chk("unbuf_abort", 32'h1, {31'h0, ab});
    err_en = 1'b0;
    // Reset with writes queued empties the buffer and clears the enable.
    cpw(4'h1, 32'h0000_0009);
    acc(1'b1, 1'b0, 1'b0, 1'b1, 3'd3, 32'h0000_4000, 32'h0);
    acc(1'b1, 1'b0, 1'b0, 1'b1, 3'd3, 32'h0000_4010, 32'h0);
    n0 = wr_cnt;
    rst_b = 1'b0;
    tick();
    chk("rst_ext_req", 32'h0, {31'h0, ext_req_q});
    rst_b = 1'b1;
    repeat (100) tick();
    chk("rst_flushed", n0, wr_cnt);
    cpr(4'h1);
    chk("rst_ctrl", 32'h0, rd);
    test_done();
  end

  // A hang is cut short well past the expected run length.
  initial begin
    repeat (8000) @(posedge clock);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire

// >>> inc/cache_wbuf_pkg.sv
// Constants, register map and state type for the cache, write buffer and attribute control.
// How it works
// - Split mode with split 11: instructions fill banks 0 to 2, data bank 3.
// - Split 01: instruction bank 0, data banks 1 to 3; split 10: two each.
// - In split mode each section is associative over its own allocated banks.
// - All banks are searched on every access, even with the cache disabled.
// - A cacheable non-atomic read miss fetches a four-word line into a permitted bank.
// - Uncacheable reads that miss go external and never allocate or write a line.
// - Writes update a hit line and always go to memory; no write allocate.
// - Writing the flush register invalidates all unlocked banks at once.
// - The write buffer holds eight data words and four addresses.
// - Buffer enable is control bit 3; reset clears it and empties the buffer.
// - Only writes with buffer enabled and area bufferable enter the buffer.
// - A write takes one data slot; a sequential word extends the newest address slot.
// - A buffered write without room stalls the core until room frees up.
// - An unbuffered write waits for an empty buffer and its external end.
// - The write phase of an atomic sequence is always unbuffered.
// - Buffered writes ignore the error input; queued writes drain after disable.
// - Protection enable is bit 0, reset low; off means permit, uncached, unbuffered.
// - Eight cacheable bits, reset low, gate linefill only, never the search.
// - Eight bufferable bits, reset low, route writes to the enabled buffer.
// - Two permission bits per area for eight areas, area 0 lowest.
// - Permission 00 none, 01 supervisor only, 10 user read-only, 11 full.
// - Register 0 reads an identity, writing 7 flushes, 4, 6 and 8 to 15 reserved.
package cache_wbuf_pkg;
  localparam int NBANK   = 4;
  localparam int LINES   = 128;
  localparam int WB_DATA = 8;
  localparam int WB_ADDR = 4;
  localparam logic [3:0] REG_ID    = 4'h0;
  localparam logic [3:0] REG_CTRL  = 4'h1;
  localparam logic [3:0] REG_CACHE = 4'h2;
  localparam logic [3:0] REG_BUF   = 4'h3;
  localparam logic [3:0] REG_PERM  = 4'h5;
  localparam logic [3:0] REG_FLUSH = 4'h7;
  localparam int CTL_PROT  = 0;
  localparam int CTL_CACHE = 2;
  localparam int CTL_WBUF  = 3;
  localparam int CTL_SPLIT = 4;
  localparam int CTL_FORCE = 5;
  localparam int CTL_LOCK  = 6;
  localparam int CTL_BANK  = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0]  MASK_RST = 8'h00;
  localparam logic [15:0] PERM_RST = 16'h0000;
  localparam logic [15:0] LFSR_RST = 16'hace1;
  localparam logic [1:0] PERM_NONE = 2'h0;
  localparam logic [1:0] PERM_SVC  = 2'h1;
  localparam logic [1:0] PERM_URO  = 2'h2;
  localparam logic [1:0] PERM_FULL = 2'h3;
  localparam logic [1:0] LAST_WORD = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_EXT, ST_FILL} st_t;
endpackage

// >>> rtl/cache_wbuf_region_attr_ctrl.sv
// Unified cache, write buffer and per-area attribute control on the core memory side.
`timescale 1ns/1ps
`default_nettype none
module cache_wbuf_region_attr_ctrl #(
  parameter logic [31:0] ID_VALUE = 32'h1234_5678  // Arbitrary identity value.
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        cp_wr,
  input  wire logic        cp_rd,
  input  wire logic [3:0]  cp_reg,
  input  wire logic [31:0] cp_wdata,
  output var  logic [31:0] cp_rdata_q,
  input  wire logic        core_req,
  input  wire logic        core_write,
  input  wire logic        core_instr,
  input  wire logic        core_seq,
  input  wire logic        core_atomic,
  input  wire logic        core_priv,
  input  wire logic [2:0]  core_area,
  input  wire logic [31:0] core_addr,
  input  wire logic [31:0] core_wdata,
  output var  logic        core_done_q,
  output var  logic        core_abort_q,
  output var  logic [31:0] core_rdata_q,
  output var  logic        ext_req_q,
  output var  logic        ext_write_q,
  output var  logic [31:0] ext_addr_q,
  output var  logic [31:0] ext_wdata_q,
  input  wire logic        ext_done,
  input  wire logic        ext_error,
  input  wire logic [31:0] ext_rdata
);
  // Permission decode for one area code.
  function automatic logic perm_ok(input logic [1:0] c, input logic priv, input logic wr);
    unique case (c)
      cache_wbuf_pkg::PERM_NONE: perm_ok = 1'b0;
      cache_wbuf_pkg::PERM_SVC:  perm_ok = priv;
      cache_wbuf_pkg::PERM_URO:  perm_ok = priv || !wr;
      cache_wbuf_pkg::PERM_FULL: perm_ok = 1'b1;
    endcase
  endfunction

  // Folds a random pair into a bank offset below cnt without a divider.
  function automatic logic [1:0] pick(input logic [2:0] cnt, input logic [1:0] r);
    if (cnt <= 3'h1) pick = 2'h0;
    else if ({1'b0, r} < cnt) pick = r;
    else pick = r - cnt[1:0];
  endfunction

  // Banks kept out of replacement and flush for a lock count.
  function automatic logic [3:0] lmask(input logic [1:0] l);
    unique case (l)
      2'h0: lmask = 4'h0;
      2'h1: lmask = 4'h1;
      2'h2: lmask = 4'h3;
      2'h3: lmask = 4'h7;
    endcase
  endfunction

  logic [31:0]       ctrl_q;
  logic [7:0]        cmask_q;
  logic [7:0]        bmask_q;
  logic [15:0]       perm_q;
  logic [15:0]       lfsr_q;
  cache_wbuf_pkg::st_t state_q;
  logic [31:0]       rq_addr_q;
  logic [31:0]       rq_wdata_q;
  logic              rq_write_q;
  logic              rq_fill_q;
  logic              rq_instr_q;
  logic [1:0]        vict_q;
  logic [1:0]        fcnt_q;
  logic              drain_q;
  logic [20:0]       tag_q  [cache_wbuf_pkg::NBANK][cache_wbuf_pkg::LINES];
  logic [31:0]       data_q [cache_wbuf_pkg::NBANK][cache_wbuf_pkg::LINES][4];
  logic [127:0]      valid_q [cache_wbuf_pkg::NBANK];
  logic [29:0]       sa_q [cache_wbuf_pkg::WB_ADDR];
  logic [3:0]        sn_q [cache_wbuf_pkg::WB_ADDR];
  logic [31:0]       dq_q [cache_wbuf_pkg::WB_DATA];
  logic [1:0]        shead_q;
  logic [1:0]        stail_q;
  logic [2:0]        scnt_q;
  logic [2:0]        dhead_q;
  logic [2:0]        dtail_q;
  logic [3:0]        dcnt_q;
  logic [3:0]        hit_v;

  // Control fields.
  wire       prot_en = ctrl_q[cache_wbuf_pkg::CTL_PROT];
  wire       split   = ctrl_q[cache_wbuf_pkg::CTL_SPLIT];
  wire       force_b = ctrl_q[cache_wbuf_pkg::CTL_FORCE];
  wire [1:0] lock_f  = ctrl_q[cache_wbuf_pkg::CTL_LOCK +: 2];
  wire [1:0] bank_f  = ctrl_q[cache_wbuf_pkg::CTL_BANK +: 2];

  // Address split and full search of every bank, enabled or not.
  wire [20:0] a_tag = core_addr[31:11];
  wire [6:0]  a_idx = core_addr[10:4];
  wire [1:0]  a_wrd = core_addr[3:2];
  for (genvar b = 0; b < cache_wbuf_pkg::NBANK; b++) begin : g_hit
    assign hit_v[b] = valid_q[b][a_idx] && tag_q[b][a_idx] == a_tag;
  end
  wire       hit   = |hit_v;
  wire [1:0] hit_b = hit_v[3] ? 2'h3 : hit_v[2] ? 2'h2 : hit_v[1] ? 2'h1 : 2'h0;

  // Area attributes; with protection off all is permitted and plain.
  wire [1:0] pcode     = perm_q[2*core_area +: 2];
  wire       allowed   = !prot_en || perm_ok(pcode, core_priv, core_write);
  wire       cacheable = prot_en && ctrl_q[cache_wbuf_pkg::CTL_CACHE] && cmask_q[core_area]
                         && !(force_b && core_instr);
  wire       bufable   = prot_en && ctrl_q[cache_wbuf_pkg::CTL_WBUF] && bmask_q[core_area]
                         && !core_atomic;

  // Buffer room; a sequential word extends the newest address slot.
  wire pop_w  = drain_q && ext_done;
  wire pop_s  = pop_w && sn_q[shead_q] == 4'h1;
  wire extend = core_seq && scnt_q != 3'h0 && !pop_w;
  wire space  = dcnt_q != 4'h8 && (extend || scnt_q != 3'h4);

  // Request decode; a request is taken only in idle with no answer showing.
  wire take     = state_q == cache_wbuf_pkg::ST_IDLE && core_req && !core_done_q;
  wire good     = take && allowed;
  wire push     = good && core_write && bufable && space;
  wire rd_hit   = good && !core_write && hit && !core_atomic;
  wire to_wait  = good && (core_write ? !bufable : !(hit && !core_atomic));
  wire cwr_core = good && core_write && hit && (!bufable || space);
  wire bus_free = dcnt_q == 4'h0 && !ext_req_q;
  wire go_wait  = state_q == cache_wbuf_pkg::ST_WAIT && bus_free;
  wire fill_go  = go_wait && rq_fill_q;
  wire in_fill  = state_q == cache_wbuf_pkg::ST_FILL;
  wire core_ext = ext_req_q && !drain_q && ext_done;
  wire fin_ext  = core_ext && (state_q == cache_wbuf_pkg::ST_EXT || ext_error
                  || fcnt_q == cache_wbuf_pkg::LAST_WORD);
  wire drain_go = !ext_req_q && dcnt_q != 4'h0 && state_q != cache_wbuf_pkg::ST_EXT
                  && !in_fill;

  // Victim range by mode: forced bank, split section, or unlocked banks.
  wire       isec   = split && rq_instr_q;
  wire [1:0] alo    = force_b ? bank_f : isec ? 2'h0 : lock_f;
  wire [2:0] acnt   = force_b ? 3'h1 : isec ? {1'b0, lock_f} : 3'h4 - {1'b0, lock_f};
  wire [1:0] victim = alo + pick(acnt, lfsr_q[1:0]);
  // Split mode reuses the lock field, so nothing is held back from a flush there.
  wire [3:0] locked = split ? 4'h0 : lmask(lock_f);
  wire       flush  = cp_wr && cp_reg == cache_wbuf_pkg::REG_FLUSH;

  // Register read selection; reserved and write-only registers read zero.
  wire [31:0] rsel = cp_reg == cache_wbuf_pkg::REG_ID    ? ID_VALUE :
                     cp_reg == cache_wbuf_pkg::REG_CTRL  ? ctrl_q :
                     cp_reg == cache_wbuf_pkg::REG_CACHE ? {24'h00_0000, cmask_q} :
                     cp_reg == cache_wbuf_pkg::REG_BUF   ? {24'h00_0000, bmask_q} :
                     cp_reg == cache_wbuf_pkg::REG_PERM  ? {16'h0000, perm_q} : 32'h0000_0000;

  // Software registers; illegal split and force combinations are not policed.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q     <= cache_wbuf_pkg::CTRL_RST;
      cmask_q    <= cache_wbuf_pkg::MASK_RST;
      bmask_q    <= cache_wbuf_pkg::MASK_RST;
      perm_q     <= cache_wbuf_pkg::PERM_RST;
      cp_rdata_q <= 32'h0000_0000;
    end else begin
      cp_rdata_q <= cp_rd ? rsel : 32'h0000_0000;
      if (cp_wr && cp_reg == cache_wbuf_pkg::REG_CTRL) ctrl_q <= cp_wdata;
      if (cp_wr && cp_reg == cache_wbuf_pkg::REG_CACHE) cmask_q <= cp_wdata[7:0];
      if (cp_wr && cp_reg == cache_wbuf_pkg::REG_BUF) bmask_q <= cp_wdata[7:0];
      if (cp_wr && cp_reg == cache_wbuf_pkg::REG_PERM) perm_q <= cp_wdata[15:0];
    end
  end

  // Sequencer, request latch and the answer to the core.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= cache_wbuf_pkg::ST_IDLE;
      lfsr_q       <= cache_wbuf_pkg::LFSR_RST;
      {rq_write_q, rq_fill_q, rq_instr_q} <= 3'h0;
      rq_addr_q    <= 32'h0000_0000;
      rq_wdata_q   <= 32'h0000_0000;
      vict_q       <= 2'h0;
      fcnt_q       <= 2'h0;
      core_done_q  <= 1'b0;
      core_abort_q <= 1'b0;
      core_rdata_q <= 32'h0000_0000;
    end else begin
      lfsr_q       <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      core_done_q  <= (take && (!allowed || push || rd_hit)) || fin_ext;
      core_abort_q <= (take && !allowed) || (fin_ext && ext_error);
      if (rd_hit) core_rdata_q <= data_q[hit_b][a_idx][a_wrd];
      if (core_ext && (!in_fill || fcnt_q == rq_addr_q[3:2])) core_rdata_q <= ext_rdata;
      if (take) begin
        rq_addr_q  <= core_addr;
        rq_wdata_q <= core_wdata;
        rq_write_q <= core_write;
        rq_instr_q <= core_instr;
        rq_fill_q  <= !core_write && cacheable && !core_atomic;
      end
      if (fill_go) vict_q <= victim;
      if (fill_go) fcnt_q <= 2'h0;
      else if (in_fill && core_ext) fcnt_q <= fcnt_q + 2'h1;
      unique case (state_q)
        cache_wbuf_pkg::ST_IDLE: if (to_wait) state_q <= cache_wbuf_pkg::ST_WAIT;
        cache_wbuf_pkg::ST_WAIT: if (bus_free) state_q <= rq_fill_q ?
                                   cache_wbuf_pkg::ST_FILL : cache_wbuf_pkg::ST_EXT;
        cache_wbuf_pkg::ST_EXT:  if (core_ext) state_q <= cache_wbuf_pkg::ST_IDLE;
        cache_wbuf_pkg::ST_FILL: if (fin_ext) state_q <= cache_wbuf_pkg::ST_IDLE;
      endcase
    end
  end

  // External bus: buffer drain owns it first, core accesses wait for it to empty.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_req_q   <= 1'b0;
      ext_write_q <= 1'b0;
      ext_addr_q  <= 32'h0000_0000;
      ext_wdata_q <= 32'h0000_0000;
      drain_q     <= 1'b0;
    end else if (ext_req_q) begin
      if (ext_done && in_fill && !drain_q && !fin_ext) begin
        ext_addr_q <= ext_addr_q + 32'h0000_0004;
      end else if (ext_done) begin
        ext_req_q <= 1'b0;
        drain_q   <= 1'b0;
      end
    end else if (drain_go) begin
      ext_req_q   <= 1'b1;
      ext_write_q <= 1'b1;
      ext_addr_q  <= {sa_q[shead_q], 2'h0};
      ext_wdata_q <= dq_q[dhead_q];
      drain_q     <= 1'b1;
    end else if (go_wait) begin
      ext_req_q   <= 1'b1;
      ext_write_q <= rq_write_q;
      ext_addr_q  <= rq_fill_q ? {rq_addr_q[31:4], 4'h0} : rq_addr_q;
      ext_wdata_q <= rq_wdata_q;
    end
  end

  // Line storage and buffer words carry no reset; valid bits and counts guard them.
  always_ff @(posedge clock) begin
    if (cwr_core) data_q[hit_b][a_idx][a_wrd] <= core_wdata;
    if (in_fill && core_ext) data_q[vict_q][rq_addr_q[10:4]][fcnt_q] <= ext_rdata;
    if (fill_go) tag_q[victim][rq_addr_q[10:4]] <= rq_addr_q[31:11];
    if (push) dq_q[dtail_q] <= core_wdata;
  end

  // Valid bits: a line is hidden while it fills; flush wins last.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int b = 0; b < cache_wbuf_pkg::NBANK; b++) valid_q[b] <= '0;
    end else begin
      if (fill_go) valid_q[victim][rq_addr_q[10:4]] <= 1'b0;
      if (fin_ext && in_fill && !ext_error) valid_q[vict_q][rq_addr_q[10:4]] <= 1'b1;
      for (int b = 0; b < cache_wbuf_pkg::NBANK; b++) begin
        if (flush && !locked[b]) valid_q[b] <= '0;
      end
    end
  end

  // Write buffer slots; reset empties them, disabling the buffer does not.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int s = 0; s < cache_wbuf_pkg::WB_ADDR; s++) begin
        sa_q[s] <= 30'h0000_0000;
        sn_q[s] <= 4'h0;
      end
      {shead_q, stail_q} <= 4'h0;
      {dhead_q, dtail_q} <= 6'h00;
      scnt_q <= 3'h0;
      dcnt_q <= 4'h0;
    end else begin
      if (push && !extend) begin
        sa_q[stail_q] <= core_addr[31:2];
        sn_q[stail_q] <= 4'h1;
      end
      if (push && extend) sn_q[stail_q - 2'h1] <= sn_q[stail_q - 2'h1] + 4'h1;
      if (pop_w) begin
        sa_q[shead_q] <= sa_q[shead_q] + 30'h0000_0001;
        sn_q[shead_q] <= sn_q[shead_q] - 4'h1;
      end
      stail_q <= stail_q + {1'b0, push && !extend};
      shead_q <= shead_q + {1'b0, pop_s};
      scnt_q  <= scnt_q + {2'h0, push && !extend} - {2'h0, pop_s};
      dtail_q <= dtail_q + {2'h0, push};
      dhead_q <= dhead_q + {2'h0, pop_w};
      dcnt_q  <= dcnt_q + {3'h0, push} - {3'h0, pop_w};
    end
  end

  // Checks on the decisions above.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_split_three: assert property (
    fill_go && split && lock_f == 2'h3 |-> (rq_instr_q ? victim != 2'h3 : victim == 2'h3))
    else $error("split 11 victim outside its section");
  chk_split_one: assert property (
    fill_go && split && lock_f == 2'h1 |-> (rq_instr_q == (victim == 2'h0)))
    else $error("split 01 victim outside its section");
  chk_fill_done: assert property (
    in_fill && core_ext && !ext_error && fcnt_q == 2'h3
    |=> core_done_q && valid_q[vict_q][rq_addr_q[10:4]] && state_q == cache_wbuf_pkg::ST_IDLE)
    else $error("line fill did not finish after four words");
  chk_uncached_rd: assert property (
    good && !core_write && !cacheable && !hit |=> state_q == cache_wbuf_pkg::ST_WAIT && !rq_fill_q)
    else $error("uncacheable read would allocate");
  chk_no_wr_alloc: assert property (
    good && core_write && !bufable |=> !rq_fill_q ##1 !in_fill)
    else $error("write miss allocated a line");
  chk_flush_clear: assert property (
    flush && !in_fill |=> valid_q[3] == '0)
    else $error("flush left bank 3 valid");
  chk_wb_bounds: assert property (
    dcnt_q <= 4'h8 && scnt_q <= 3'h4 && (dcnt_q == 4'h0) == (scnt_q == 3'h0))
    else $error("write buffer counts out of range");
  chk_buf_gate: assert property (
    push |-> ctrl_q[cache_wbuf_pkg::CTL_WBUF] && bmask_q[core_area])
    else $error("write buffered without enable");
  chk_buf_fast: assert property (
    push |=> core_done_q && !core_abort_q && dcnt_q != 4'h0)
    else $error("buffered write not answered next cycle");
  chk_unbuf_empty: assert property (
    $rose(ext_req_q) && !drain_q |-> dcnt_q == 4'h0)
    else $error("core access started with buffer not empty");
  chk_atomic_unbuf: assert property (
    take && core_write && core_atomic |-> !push)
    else $error("atomic write entered the buffer");
  chk_drain_quiet: assert property (
    drain_q && ext_done && ext_error && !take |=> !core_abort_q)
    else $error("buffered write was aborted");
  chk_prot_off: assert property (
    take && !prot_en |-> allowed && !bufable && !cacheable)
    else $error("attributes applied with protection off");
  chk_user_ro: assert property (
    take && prot_en && !core_priv && core_write && pcode == cache_wbuf_pkg::PERM_URO
    |=> core_done_q && core_abort_q)
    else $error("user write to read-only area not aborted");

  cov_line_fill: cover property (fill_go ##[1:40] (in_fill && fin_ext && !ext_error));
  cov_buf_full:  cover property (take && core_write && bufable && !space);
  cov_seq_burst: cover property (push && extend ##1 push && extend);
endmodule
`default_nettype wire
